// [rtl/spc_chopper.v]
// constant-current pwm chopper with fault protection, one controller per phase
// Operation
// (RQ1) end on-period when sense voltage reaches the trip reference
// (RQ2) ignore sense comparator during blanking after every turn-on
// (RQ3) blanking is 1.5 us standard or 3.0 us long option
// (RQ4) on-time never shorter than the blanking interval
// (RQ5) off-time fixed by oscillator-timed counter, not by current
// (RQ6) off-time is one of three levels chosen by stepping sequence
// (RQ7) switch the rectifying transistor during off-time
// (RQ8) insert about 0.5 us dead time between main and rectifier switching
// (RQ9) sense voltage above short threshold disables all outputs at once
// (RQ10) positive sense voltage during off-time flags coil-open event
// (RQ11) three consecutive coil-open off-periods disable the outputs
// (RQ12) ignore positive sense voltage inside the open non-detect window
// (RQ13) over-temperature indication disables all outputs
// (RQ14) trip reference refreshed on every step clock from ratios
// (RQ15) controller leaves protection by full sleep input or power cycle
// (RQ16) trip reference equals external reference over 3 times ratio
// (RQ17) intervals timed by counters with parameterised terminal counts
// (RQ18) protection latches outputs off with fault flag until release
`default_nettype none
`include "spc_chopper_regs.vh"

// ==========================================================
// per-phase chopper
module spc_phase #(
   parameter LONG_BLANK = 0
) (
   input  wire                     i_clock,
   input  wire                     i_rst_n,
   input  wire                     i_enable,
   input  wire                     i_trip_cmp,
   input  wire                     i_sense_pos,
   input  wire [1:0]               i_off_sel,
   output reg                      o_main_on,
   output reg                      o_rect_on,
   output reg                      o_open_evt,
   output reg                      o_off_end
);
   localparam [`SPC_CNT_W-1:0] BLANK_CYC = LONG_BLANK ?
      `SPC_BLANK_LONG_CYC : `SPC_BLANK_STD_CYC; // (RQ3)
   localparam [`SPC_CNT_W-1:0] DEAD_CYC = `SPC_DEAD_CYC;
   localparam [`SPC_CNT_W-1:0] OPEN_CYC = `SPC_OPEN_WIN_CYC;
   localparam [`SPC_CNT_W-1:0] OFF0_CYC = `SPC_OFF_LVL0_CYC;
   localparam [`SPC_CNT_W-1:0] OFF1_CYC = `SPC_OFF_LVL1_CYC;
   localparam [`SPC_CNT_W-1:0] OFF2_CYC = `SPC_OFF_LVL2_CYC;

   localparam [2:0] ST_IDLE  = 3'h0;
   localparam [2:0] ST_BLANK = 3'h1;
   localparam [2:0] ST_ON    = 3'h2;
   localparam [2:0] ST_DT1   = 3'h3;
   localparam [2:0] ST_RECT  = 3'h4;
   localparam [2:0] ST_DT2   = 3'h5;

   reg [2:0]             state_q;
   reg [`SPC_CNT_W-1:0]  cnt_q;
   reg [`SPC_CNT_W-1:0]  off_cyc;
   reg [`SPC_CNT_W-1:0]  off_elapsed_q;

   always @* begin
      case (i_off_sel) // (RQ6)
         2'h0:    off_cyc = OFF0_CYC;
         2'h1:    off_cyc = OFF1_CYC;
         default: off_cyc = OFF2_CYC;
      endcase
   end

   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q       <= ST_IDLE;
         cnt_q         <= {`SPC_CNT_W{1'b0}};
         off_elapsed_q <= {`SPC_CNT_W{1'b0}};
         o_main_on     <= 1'b0;
         o_rect_on     <= 1'b0;
         o_open_evt    <= 1'b0;
         o_off_end     <= 1'b0;
      end else begin
         o_off_end <= 1'b0;
         if (!i_enable) begin
            // coast: everything off immediately
            state_q    <= ST_IDLE;
            o_main_on  <= 1'b0;
            o_rect_on  <= 1'b0;
            o_open_evt <= 1'b0;
         end else begin
            case (state_q)
               ST_IDLE: begin
                  state_q   <= ST_BLANK;
                  cnt_q     <= BLANK_CYC - 9'h001;
                  o_main_on <= 1'b1;
               end
               ST_BLANK: begin
                  // comparator not looked at here, so on-time >= blanking
                  if (cnt_q == 9'h000) begin // (RQ2) (RQ4) (RQ17)
                     state_q <= ST_ON;
                  end else begin
                     cnt_q <= cnt_q - 9'h001;
                  end
               end
               ST_ON: begin
                  if (i_trip_cmp) begin // (RQ1)
                     state_q       <= ST_DT1;
                     o_main_on     <= 1'b0;
                     cnt_q         <= DEAD_CYC - 9'h001;
                     off_elapsed_q <= {`SPC_CNT_W{1'b0}};
                     o_open_evt    <= 1'b0;
                  end
               end
               ST_DT1: begin
                  off_elapsed_q <= off_elapsed_q + 9'h001;
                  if (cnt_q == 9'h000) begin // (RQ8)
                     state_q   <= ST_RECT;
                     o_rect_on <= 1'b1; // (RQ7)
                  end else begin
                     cnt_q <= cnt_q - 9'h001;
                  end
               end
               ST_RECT: begin
                  off_elapsed_q <= off_elapsed_q + 9'h001;
                  if (i_sense_pos && off_elapsed_q >= OPEN_CYC) begin // (RQ10) (RQ12)
                     o_open_evt <= 1'b1;
                  end
                  // off-time includes both dead-time slots
                  if (off_elapsed_q + DEAD_CYC >= off_cyc - 9'h001) begin // (RQ5)
                     state_q   <= ST_DT2;
                     o_rect_on <= 1'b0;
                     cnt_q     <= DEAD_CYC - 9'h001;
                  end
               end
               ST_DT2: begin
                  if (cnt_q == 9'h000) begin // (RQ8)
                     state_q   <= ST_BLANK;
                     cnt_q     <= BLANK_CYC - 9'h001;
                     o_main_on <= 1'b1;
                     o_off_end <= 1'b1;
                  end else begin
                     cnt_q <= cnt_q - 9'h001;
                  end
               end
               default: state_q <= ST_IDLE;
            endcase
         end
      end
   end
endmodule // spc_phase

// ==========================================================
// top: two phases, trip references, protection latch
module spc_chopper #(
   parameter LONG_BLANK = 0
) (
   input  wire                     i_clock,
   input  wire                     i_rst_n,
   input  wire                     i_step_clk,
   input  wire [1:0]               i_seq_mode,
   input  wire [`SPC_RATIO_W-1:0]  i_ratio_a,
   input  wire [`SPC_RATIO_W-1:0]  i_ratio_b,
   input  wire [`SPC_REF_W-1:0]    i_ext_ref,
   input  wire [`SPC_REF_W-1:0]    i_sense_a,
   input  wire [`SPC_REF_W-1:0]    i_sense_b,
   input  wire                     i_sense_pos_a,
   input  wire                     i_sense_pos_b,
   input  wire                     i_short_a,
   input  wire                     i_short_b,
   input  wire                     i_over_temp,
   input  wire                     i_full_sleep_input,
   output wire                     o_main_a,
   output wire                     o_rect_a,
   output wire                     o_main_b,
   output wire                     o_rect_b,
   output reg  [`SPC_REF_W-1:0]    o_trip_ref_a,
   output reg  [`SPC_REF_W-1:0]    o_trip_ref_b,
   output reg                      o_fault,
   output reg  [1:0]               o_fault_cause
);
   // ==========================================================
   // input synchronisers (pins are asynchronous to i_clock)
   localparam NSYNC = 7;
   wire [NSYNC-1:0] raw = {i_step_clk, i_sense_pos_a, i_sense_pos_b, i_short_a,
                           i_short_b, i_over_temp, i_full_sleep_input};
   reg  [NSYNC-1:0] s1_q;
   reg  [NSYNC-1:0] s2_q;
   reg              step_prev_q;
   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s1_q        <= {NSYNC{1'b0}};
         s2_q        <= {NSYNC{1'b0}};
         step_prev_q <= 1'b0;
      end else begin
         s1_q        <= raw;
         s2_q        <= s1_q;
         step_prev_q <= s2_q[6];
      end
   end
   wire step_rise = s2_q[6] & ~step_prev_q;
   wire spos_a = s2_q[5];
   wire spos_b = s2_q[4];
   wire short_any = s2_q[3] | s2_q[2];
   wire hot = s2_q[1];
   wire sleep = s2_q[0];

   // ==========================================================
   // trip references, refreshed on each rising step edge
   wire [`SPC_REF_W+`SPC_RATIO_W-1:0] prod_a = i_ext_ref * i_ratio_a;
   wire [`SPC_REF_W+`SPC_RATIO_W-1:0] prod_b = i_ext_ref * i_ratio_b;
   wire [`SPC_REF_W+`SPC_RATIO_W-1:0] div_a = prod_a / 18'h00003;
   wire [`SPC_REF_W+`SPC_RATIO_W-1:0] div_b = prod_b / 18'h00003;
   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_trip_ref_a <= {`SPC_REF_W{1'b0}};
         o_trip_ref_b <= {`SPC_REF_W{1'b0}};
      end else if (step_rise) begin // (RQ14)
         // ratio is a fraction of 256; ref/3 times ratio
         o_trip_ref_a <= div_a[`SPC_REF_W+`SPC_RATIO_W-1:`SPC_RATIO_W]; // (RQ16)
         o_trip_ref_b <= div_b[`SPC_REF_W+`SPC_RATIO_W-1:`SPC_RATIO_W]; // (RQ16)
      end
   end

   // ==========================================================
   // protection
   wire       open_evt_a;
   wire       open_evt_b;
   wire       off_end_a;
   wire       off_end_b;
   reg  [1:0] open_cnt_a_q;
   reg  [1:0] open_cnt_b_q;
   wire       enable = ~o_fault & ~sleep;

   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_fault       <= 1'b0;
         o_fault_cause <= 2'h0;
         open_cnt_a_q  <= 2'h0;
         open_cnt_b_q  <= 2'h0;
      end else if (sleep) begin
         // full sleep releases; a short or overheat seen meanwhile still latches
         o_fault       <= short_any | hot; // (RQ15) (RQ18)
         o_fault_cause <= short_any ? 2'h1 : {hot, hot};
         open_cnt_a_q  <= 2'h0;
         open_cnt_b_q  <= 2'h0;
      end else begin
         if (off_end_a) begin
            open_cnt_a_q <= open_evt_a ? open_cnt_a_q + 2'h1 : 2'h0; // (RQ11)
         end
         if (off_end_b) begin
            open_cnt_b_q <= open_evt_b ? open_cnt_b_q + 2'h1 : 2'h0; // (RQ11)
         end
         if (!o_fault) begin
            if (short_any) begin // (RQ9)
               o_fault       <= 1'b1;
               o_fault_cause <= 2'h1;
            end else if (hot) begin // (RQ13)
               o_fault       <= 1'b1;
               o_fault_cause <= 2'h3;
            end else if (open_cnt_a_q == `SPC_OPEN_COUNT ||
                         open_cnt_b_q == `SPC_OPEN_COUNT) begin // (RQ11)
               o_fault       <= 1'b1;
               o_fault_cause <= 2'h2;
            end
         end
      end
   end

   // ==========================================================
   // phase controllers; comparators done on synchronous digital sense words
   wire main_a;
   wire rect_a;
   wire main_b;
   wire rect_b;
   spc_phase #(.LONG_BLANK(LONG_BLANK)) u_phase_a (
      .i_clock    (i_clock),
      .i_rst_n    (i_rst_n),
      .i_enable   (enable),
      .i_trip_cmp (i_sense_a >= o_trip_ref_a),
      .i_sense_pos(spos_a),
      .i_off_sel  (i_seq_mode),
      .o_main_on  (main_a),
      .o_rect_on  (rect_a),
      .o_open_evt (open_evt_a),
      .o_off_end  (off_end_a)
   );
   spc_phase #(.LONG_BLANK(LONG_BLANK)) u_phase_b (
      .i_clock    (i_clock),
      .i_rst_n    (i_rst_n),
      .i_enable   (enable),
      .i_trip_cmp (i_sense_b >= o_trip_ref_b),
      .i_sense_pos(spos_b),
      .i_off_sel  (i_seq_mode),
      .o_main_on  (main_b),
      .o_rect_on  (rect_b),
      .o_open_evt (open_evt_b),
      .o_off_end  (off_end_b)
   );
   // gate with live fault so a short kills drive without waiting a cycle
   assign o_main_a = main_a & enable & ~short_any; // (RQ9)
   assign o_rect_a = rect_a & enable & ~short_any;
   assign o_main_b = main_b & enable & ~short_any;
   assign o_rect_b = rect_b & enable & ~short_any;
endmodule // spc_chopper
`default_nettype wire

// [rtl/spc_chopper_regs.vh]
// timing constants and encodings for the stepper pwm chopper
`ifndef SPC_CHOPPER_REGS_VH
`define SPC_CHOPPER_REGS_VH
`define SPC_CLK_MHZ          50
// times in nanoseconds, as printed
`define SPC_BLANK_STD_NS     1500
`define SPC_BLANK_LONG_NS    3000
`define SPC_DEAD_NS          500
`define SPC_OFF_LVL0_NS      8000
`define SPC_OFF_LVL1_NS      6000
`define SPC_OFF_LVL2_NS      4000
`define SPC_OPEN_WIN_NS      1000
// same times in clock cycles; least times round up, longest round down
`define SPC_BLANK_STD_CYC    9'h04B
`define SPC_BLANK_LONG_CYC   9'h096
`define SPC_DEAD_CYC         9'h019
`define SPC_OFF_LVL0_CYC     9'h190
`define SPC_OFF_LVL1_CYC     9'h12C
`define SPC_OFF_LVL2_CYC     9'h0C8
`define SPC_OPEN_WIN_CYC     9'h032
`define SPC_OPEN_COUNT       2'h3
`define SPC_RATIO_W          8
`define SPC_REF_W            10
`define SPC_CNT_W            9
`endif

// [testbench/spc_chopper_monitor.sv]
// concurrent checks on the chopper top ports
`default_nettype none
module spc_chopper_monitor #(
   parameter LONG_BLANK = 0
) (
   input wire logic       i_clock,
   input wire logic       i_rst_n,
   input wire logic       i_step_clk,
   input wire logic [1:0] i_seq_mode,
   input wire logic [7:0] i_ratio_a,
   input wire logic [9:0] i_ext_ref,
   input wire logic [9:0] i_sense_a,
   input wire logic       i_short_a,
   input wire logic       i_short_b,
   input wire logic       i_over_temp,
   input wire logic       i_full_sleep_input,
   input wire logic       o_main_a,
   input wire logic       o_rect_a,
   input wire logic       o_main_b,
   input wire logic       o_rect_b,
   input wire logic [9:0] o_trip_ref_a,
   input wire logic       o_fault,
   input wire logic [1:0] o_fault_cause
);
   timeunit 1ns;
   timeprecision 1ps;
   // ======
   // helper counters
   localparam int MINON = LONG_BLANK ? 150 : 75;
   logic [7:0]       on_q;
   logic [8:0]       off_q;
   logic [3:0]       hit_q, slp_q;
   logic             prev_q;
   wire logic [17:0] prod = i_ext_ref * i_ratio_a;
   wire logic [8:0]  lvl = (i_seq_mode == 2'h0) ? 9'h190 : (i_seq_mode == 2'h1) ? 9'h12C : 9'h0C8;
   // faults and sleep cut pulses short, so those windows are excluded
   wire logic        calm = !o_fault && hit_q == 4'h0;
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         on_q <= 8'h00;
         off_q <= 9'h000;
         hit_q <= 4'h0;
         slp_q <= 4'h0;
         prev_q <= 1'b0;
      end else begin
         prev_q <= o_main_a;
         hit_q <= {hit_q[2:0], i_short_a | i_short_b | i_over_temp | i_full_sleep_input};
         slp_q <= {slp_q[2:0], i_full_sleep_input};
         if (o_main_a) on_q <= prev_q ? on_q + {7'h00, on_q != 8'hFF} : 8'h01;
         off_q <= o_main_a ? 9'h000 : off_q + {8'h00, off_q != 9'h1FF};
      end
   end
   // ======
   // properties
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_n);
   no_overlap_a: assert property (!(o_main_a && o_rect_a) && !(o_main_b && o_rect_b))
      else $error("main and rectifier on together");
   dead_gap_a: assert property ($rose(o_rect_a) |-> !$past(o_main_a, 20))
      else $error("dead time too short");
   dead_back_a: assert property ($rose(o_main_a) |-> !$past(o_rect_a, 20))
      else $error("dead time before turn-on too short");
   min_on_a: assert property ($fell(o_main_a) && calm |-> on_q >= MINON)
      else $error("on time below blanking");
   trip_end_a: assert property (o_main_a && on_q > MINON && i_sense_a >= o_trip_ref_a
      |-> ##[1:3] !o_main_a) else $error("trip did not end on time");
   short_off_a: assert property ($rose(i_short_a) && !o_fault |-> ##[1:4] (o_fault &&
      o_fault_cause == 2'h1 && !o_main_a && !o_rect_a && !o_main_b && !o_rect_b))
      else $error("short did not disable");
   heat_off_a: assert property ($rose(i_over_temp) && !o_fault |-> ##[1:4]
      (o_fault && o_fault_cause == 2'h3)) else $error("thermal did not disable");
   fault_hold_a: assert property (o_fault && !i_full_sleep_input && slp_q == 4'h0 |=> o_fault)
      else $error("fault dropped without sleep");
   fault_dark_a: assert property (o_fault |-> !(o_main_a || o_rect_a || o_main_b || o_rect_b))
      else $error("output on while faulted");
   trip_ref_a: assert property ($rose(i_step_clk) |-> ##[2:6]
      (o_trip_ref_a == 10'(prod / 18'h300))) else $error("trip reference wrong");
   off_time_a: assert property ($rose(o_main_a) && off_q > 9'h03C && off_q < 9'h1C2
      |-> off_q + 9'h002 >= lvl && off_q <= lvl + 9'h002) else $error("off time wrong");
   rect_on_a: assert property ($fell(o_main_a) && calm |-> ##[20:30] o_rect_a)
      else $error("rectifier not switched");
   cover property ($fell(o_main_a) && on_q <= MINON + 2);
   cover property (o_fault && o_fault_cause == 2'h2);
   cover property ($rose(o_rect_a));
endmodule // spc_chopper_monitor
bind spc_chopper spc_chopper_monitor #(.LONG_BLANK(LONG_BLANK)) i_spc_chopper_monitor (
   .i_clock(i_clock), .i_rst_n(i_rst_n), .i_step_clk(i_step_clk), .i_seq_mode(i_seq_mode),
   .i_ratio_a(i_ratio_a), .i_ext_ref(i_ext_ref), .i_sense_a(i_sense_a), .i_short_a(i_short_a),
   .i_short_b(i_short_b), .i_over_temp(i_over_temp), .i_full_sleep_input(i_full_sleep_input),
   .o_main_a(o_main_a), .o_rect_a(o_rect_a), .o_main_b(o_main_b), .o_rect_b(o_rect_b),
   .o_trip_ref_a(o_trip_ref_a), .o_fault(o_fault), .o_fault_cause(o_fault_cause));
`default_nettype wire

// [testbench/spc_coil_model.sv]
// coil and sense model for one phase of the chopper
`default_nettype none
module spc_coil_model (
   input  wire logic       i_clock,
   input  wire logic       i_rst_n,
   input  wire logic       i_main_on,
   input  wire logic       i_open,
   input  wire logic       i_spike,
   output var  logic [9:0] o_sense,
   output wire logic       o_sense_pos
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] off_q;
   // ======
   // current ramps only while the main switch conducts
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_sense <= 10'h000;
         off_q <= 6'h00;
      end else begin
         o_sense <= i_main_on ? o_sense + 10'h002 : 10'h000;
         off_q <= i_main_on ? 6'h00 : off_q + {5'h00, off_q != 6'h3F};
      end
   end
   // open coil keeps polarity positive all off-time, a surge only briefly
   assign o_sense_pos = !i_main_on && (i_open || (i_spike && off_q < 6'h14));
endmodule // spc_coil_model
`default_nettype wire

// [testbench/tb_top.sv]
// self-checking bench for the chopper with three coil models
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
   $display("Error %s expected %0h seen %0h", n, e, g); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic            clk = 1'b0, rst_n = 1'b0, step = 1'b0, sleep = 1'b0, temp = 1'b0;
   logic            opn = 1'b0, spk = 1'b0;
   logic [1:0]      sh = 2'h0, mode = 2'h0;
   logic [9:0]      ext = 10'h258;
   logic [7:0]      rt_a = 8'hC8, rt_b = 8'hFF;
   wire logic [9:0] sen_a, sen_b, ref_a, ref_b, sen_l;
   wire logic [1:0] cause;
   wire logic       pos_a, pos_b, ma, xa, mb, xb, flt, pos_l, ml;
   int              errors = 0, num_checks = 0, on_c, off_c;
   spc_chopper i_spc_chopper (.i_clock(clk), .i_rst_n(rst_n), .i_step_clk(step),
      .i_seq_mode(mode), .i_ratio_a(rt_a), .i_ratio_b(rt_b), .i_ext_ref(ext),
      .i_sense_a(sen_a), .i_sense_b(sen_b), .i_sense_pos_a(pos_a), .i_sense_pos_b(pos_b),
      .i_short_a(sh[0]), .i_short_b(sh[1]), .i_over_temp(temp), .i_full_sleep_input(sleep),
      .o_main_a(ma), .o_rect_a(xa), .o_main_b(mb), .o_rect_b(xb), .o_trip_ref_a(ref_a),
      .o_trip_ref_b(ref_b), .o_fault(flt), .o_fault_cause(cause));
   spc_coil_model u_coil_a (.i_clock(clk), .i_rst_n(rst_n), .i_main_on(ma), .i_open(opn),
      .i_spike(spk), .o_sense(sen_a), .o_sense_pos(pos_a));
   spc_coil_model u_coil_b (.i_clock(clk), .i_rst_n(rst_n), .i_main_on(mb), .i_open(1'b0),
      .i_spike(spk), .o_sense(sen_b), .o_sense_pos(pos_b));
   // long blanking build beside the standard one; its far side stays fault free
   spc_chopper #(.LONG_BLANK(1)) i_spc_chopper_long (.i_clock(clk), .i_rst_n(rst_n),
      .i_step_clk(step), .i_seq_mode(mode), .i_ratio_a(rt_a), .i_ratio_b(rt_b),
      .i_ext_ref(ext), .i_sense_a(sen_l), .i_sense_b(10'h3FF), .i_sense_pos_a(pos_l),
      .i_sense_pos_b(1'b0), .i_short_a(1'b0), .i_short_b(1'b0), .i_over_temp(1'b0),
      .i_full_sleep_input(1'b0), .o_main_a(ml), .o_rect_a(), .o_main_b(), .o_rect_b(),
      .o_trip_ref_a(), .o_trip_ref_b(), .o_fault(), .o_fault_cause());
   spc_coil_model u_coil_l (.i_clock(clk), .i_rst_n(rst_n), .i_main_on(ml), .i_open(1'b0),
      .i_spike(1'b0), .o_sense(sen_l), .o_sense_pos(pos_l));
   always #10 clk = ~clk;
   // ======
   // shared tasks
   task automatic wait_main(input logic v);
      int n = 0;
      while (ma !== v && n < 3000) @(negedge clk) n++;
   endtask
   task automatic meas(output int on_n, output int off_n);
      wait_main(1'b0);
      wait_main(1'b1);
      on_n = 0;
      off_n = 0;
      while (ma === 1'b1 && on_n < 3000) @(negedge clk) on_n++;
      while (ma !== 1'b1 && off_n < 3000) @(negedge clk) off_n++;
   endtask
   task automatic step_pulse(input logic [7:0] r, input logic [9:0] exp_a);
      @(posedge clk);
      rt_a <= r;
      @(posedge clk);
      step <= 1'b1;
      repeat (4) @(posedge clk);
      step <= 1'b0;
      repeat (6) @(negedge clk);
      `CHK("trip_ref_a", exp_a, ref_a)
   endtask
   // long hold first, so a latch that leaks shows up
   task automatic release_fault;
      repeat (500) @(negedge clk);
      `CHK("fault_held", 1'b1, flt)
      @(posedge clk);
      sleep <= 1'b1;
      repeat (6) @(negedge clk);
      `CHK("fault_clear", 1'b0, flt)
      @(posedge clk);
      sleep <= 1'b0;
   endtask
   // ======
   // scenarios
   task automatic t_modes;
      int lv;
      for (int m = 0; m < 4; m++) begin
         lv = (m > 2) ? 200 : 400 - 100 * m;
         wait_main(1'b1);
         @(posedge clk);
         mode <= 2'(m);
         meas(on_c, off_c);
         `CHK("on_time", 1'b1, on_c >= 76 && on_c <= 84)
         `CHK("off_time", 1'b1, off_c >= lv - 2 && off_c <= lv + 2)
      end
   endtask
   task automatic t_cut;
      for (int k = 0; k < 3; k++) begin
         @(posedge clk);
         {temp, sh} <= 3'(1 << k);
         repeat (5) @(negedge clk);
         `CHK("cause", (k == 2) ? 2'h3 : 2'h1, cause)
         `CHK("outputs", 4'h0, {ma, xa, mb, xb})
         @(posedge clk);
         {temp, sh} <= 3'h0;
         release_fault;
      end
   endtask
   task automatic t_open;
      wait_main(1'b1);
      @(posedge clk);
      opn <= 1'b1;
      meas(on_c, off_c);
      `CHK("open_early", 1'b0, flt)
      wait_main(1'b0);
      repeat (300) @(negedge clk);
      `CHK("open_cause", 2'h2, cause)
      @(posedge clk);
      opn <= 1'b0;
      release_fault;
   endtask
   task automatic t_long;
      int n = 0;
      while (ml !== 1'b0) @(negedge clk);
      while (ml !== 1'b1) @(negedge clk);
      while (ml === 1'b1 && n < 3000) @(negedge clk) n++;
      `CHK("long_on", 1'b1, n >= 150 && n <= 152)
   endtask
   task automatic give_verdict;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      step_pulse(8'hC8, 10'h09C);
      `CHK("trip_ref_b", 10'h0C7, ref_b)
      t_modes;
      step_pulse(8'h80, 10'h064);
      meas(on_c, off_c);
      `CHK("blank_on", 1'b1, on_c >= 75 && on_c <= 77)
      t_long;
      t_cut;
      t_open;
      spk <= 1'b1;
      repeat (4) meas(on_c, off_c);
      `CHK("spike_fault", 1'b0, flt)
      give_verdict;
   end
   initial begin
      #1000000;
      errors++;
      $display("Error watchdog expected done seen hang");
      give_verdict;
   end
endmodule // tb_top
`default_nettype wire
